/* File: design/cmo_status_core.sv */
// Purpose: controller status flags and 32 message objects with filtering and chaining
// Assumes: protocol engine and host logic on the same clock, pulses one cycle wide
// Notes: bit timing and frame coding live in the protocol engine outside
`timescale 1ns/1ps
// What this block does
// [R1] retry setting decides if a failed transmission stays pending
// [R2] reading main status clears the pending status interrupt
// [R3] bus-off flag follows the bus-off condition
// [R4] warning flag set when either error counter is at least 96
// [R5] error passive flag follows the error passive state
// [R6] receive success set for every good frame, matched or not
// [R7] transmit success set after a completed transmission
// [R8] three-bit last error code, zero meaning no error
// [R9] codes for stuffing, format, missing acknowledge and checksum errors
// [R10] codes for both bit error directions
// [R11] pending-transmit, unread-data and configured maps, one bit per object
// [R12] 32 objects addressed by index, separate from their identifier
// [R13] remote request sender sends without data, then becomes receiver
// [R14] remote request receiver stores request and raises interrupt
// [R15] auto responder sends its stored data on a matching request
// [R16] with id filter, frame id ANDed with mask must equal identifier
// [R17] direction filter admits only frames matching the object type
// [R18] extended filter admits only extended identifiers
// [R19] per-object transmit and receive interrupt enables
// [R20] chained objects fill in order, last object without chain flag
// [R21] software reads chained objects in ascending index order
// [R22] objects report lost data and received remote requests
// [R23] interrupt id gives highest-priority pending object as 1 to 32
// [R24] clearing read resets unread data and pending interrupt
module cmo_status_core
    import cmo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic autoRetryEn,
    input wire logic cfgWr,
    input wire logic [IDX_W-1:0] cfgIdx,
    input wire logic cfgValid,
    input wire cmo_type_e cfgType,
    input wire logic [ID_W-1:0] cfgId,
    input wire logic [ID_W-1:0] cfgMask,
    input wire logic cfgLongId,
    input wire logic cfgIdFilter,
    input wire logic cfgDirFilter,
    input wire logic cfgExtFilter,
    input wire logic cfgChain,
    input wire logic cfgTxIrqEn,
    input wire logic cfgRxIrqEn,
    input wire logic [DLC_W-1:0] cfgDlc,
    input wire logic [DATA_W-1:0] cfgData,
    input wire logic rdReq,
    input wire logic [IDX_W-1:0] rdIdx,
    input wire logic rdClear,
    output logic rdValid,
    output logic [ID_W-1:0] rdId,
    output logic rdLongId,
    output logic [DLC_W-1:0] rdDlc,
    output logic [DATA_W-1:0] rdData,
    output logic rdFresh,
    output logic rdLost,
    output logic rdRemote,
    input wire logic stsRd,
    output logic busOffFlag,
    output logic errorWarningFlag,
    output logic errorPassiveFlag,
    output logic receiveSuccessFlag,
    output logic transmitSuccessFlag,
    output logic [2:0] lastErrorCode,
    output logic statusIrqPend,
    output logic [NUM_OBJ-1:0] pendingTransmitMap,
    output logic [NUM_OBJ-1:0] unreadDataMap,
    output logic [NUM_OBJ-1:0] configuredObjectMap,
    output logic [INTID_W-1:0] intId,
    input wire logic rxFrame,
    input wire logic [ID_W-1:0] rxId,
    input wire logic rxLong,
    input wire logic rxRemote,
    input wire logic [DLC_W-1:0] rxDlc,
    input wire logic [DATA_W-1:0] rxData,
    output logic txStart,
    output logic [ID_W-1:0] txId,
    output logic txLong,
    output logic txRemote,
    output logic [DLC_W-1:0] txDlc,
    output logic [DATA_W-1:0] txData,
    input wire logic txDone,
    input wire logic txFail,
    input wire logic errEvt,
    input wire logic [2:0] errCode,
    input wire logic [7:0] tecCount,
    input wire logic [7:0] recCount,
    input wire logic busOffIn,
    input wire logic errPassiveIn
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        cmo_obj_s [NUM_OBJ-1:0] obj;
        logic txBusy;
        logic [IDX_W-1:0] txIdx;
        logic txStart;
        logic [ID_W-1:0] txId;
        logic txLong;
        logic txRemote;
        logic [DLC_W-1:0] txDlc;
        logic [DATA_W-1:0] txData;
        logic rdValid;
        logic [ID_W-1:0] rdId;
        logic rdLongId;
        logic [DLC_W-1:0] rdDlc;
        logic [DATA_W-1:0] rdData;
        logic rdFresh;
        logic rdLost;
        logic rdRemote;
        logic busOff;
        logic ewarn;
        logic epass;
        logic rxOk;
        logic txOk;
        logic [2:0] lec;
        logic stsIrq;
        logic [NUM_OBJ-1:0] txMap;
        logic [NUM_OBJ-1:0] newMap;
        logic [NUM_OBJ-1:0] valMap;
        logic [INTID_W-1:0] intId;
    } cmo_core_s;

    cmo_core_s state_q;
    cmo_core_s state_d;
    logic [NUM_OBJ-1:0] hitVec;
    logic [NUM_OBJ-1:0] rxElig;
    logic [NUM_OBJ-1:0] txReq;
    logic [NUM_OBJ-1:0] intVec;

    // lowest set index wins
    function automatic logic [IDX_W-1:0] firstSet(input logic [NUM_OBJ-1:0] vec);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int i = NUM_OBJ - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                idx = IDX_W'(i);
            end
        end
        return idx;
    endfunction : firstSet

    // ----------------------------------------
    // acceptance filters
    // ----------------------------------------
    for (genvar g = 0; g < NUM_OBJ; g++)
    begin : gMatch
        cmo_obj_match uMatch (
            .objectValidBit(state_q.obj[g].objectValidBit),
            .objType(state_q.obj[g].objType),
            .identifierFilterEnable(state_q.obj[g].identifierFilterEnable),
            .directionFilterEnable(state_q.obj[g].directionFilterEnable),
            .extendedOnlyFilter(state_q.obj[g].extendedOnlyFilter),
            .longIdentifierSelect(state_q.obj[g].longIdentifierSelect),
            .objectIdentifier(state_q.obj[g].objectIdentifier),
            .acceptanceMask(state_q.obj[g].acceptanceMask),
            .frameId(rxId),
            .frameLong(rxLong),
            .frameRemote(rxRemote),
            .hit(hitVec[g])
        );
        // [R20] a filled chain member passes the frame on
        assign rxElig[g] = hitVec[g] && !(state_q.obj[g].freshDataBit && state_q.obj[g].chainContinueFlag);
        assign txReq[g] = state_q.obj[g].objectValidBit && state_q.obj[g].transmitPendingBit;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [IDX_W-1:0] k;
        k = '0;
        state_d = state_q;
        state_d.txStart = 1'b0;
        state_d.rdValid = 1'b0;
        // [R2] status read clears first so later events win
        if (stsRd)
        begin
            state_d.stsIrq = 1'b0;
        end
        // [R12] object write by index
        if (cfgWr)
        begin
            state_d.obj[cfgIdx] = '0;
            state_d.obj[cfgIdx].objectValidBit = cfgValid;
            state_d.obj[cfgIdx].transmitPendingBit = cfgValid && (cfgType == OBJ_TX || cfgType == REMOTE_REQUEST_SENDER);
            state_d.obj[cfgIdx].transmitIrqEnable = cfgTxIrqEn;
            state_d.obj[cfgIdx].receiveIrqEnable = cfgRxIrqEn;
            state_d.obj[cfgIdx].identifierFilterEnable = cfgIdFilter;
            state_d.obj[cfgIdx].directionFilterEnable = cfgDirFilter;
            state_d.obj[cfgIdx].extendedOnlyFilter = cfgExtFilter;
            state_d.obj[cfgIdx].longIdentifierSelect = cfgLongId || (|cfgId[ID_W-1:STD_ID_W]);
            state_d.obj[cfgIdx].chainContinueFlag = cfgChain;
            state_d.obj[cfgIdx].objType = cfgType;
            state_d.obj[cfgIdx].objectIdentifier = cfgId;
            state_d.obj[cfgIdx].acceptanceMask = cfgMask;
            state_d.obj[cfgIdx].dlc = cfgDlc;
            state_d.obj[cfgIdx].data = cfgData;
        end
        // [R22] object read returns its status flags
        if (rdReq)
        begin
            state_d.rdValid = 1'b1;
            state_d.rdId = state_q.obj[rdIdx].objectIdentifier;
            state_d.rdLongId = state_q.obj[rdIdx].longIdentifierSelect;
            state_d.rdDlc = state_q.obj[rdIdx].dlc;
            state_d.rdData = state_q.obj[rdIdx].data;
            state_d.rdFresh = state_q.obj[rdIdx].freshDataBit;
            state_d.rdLost = state_q.obj[rdIdx].overwriteLostFlag;
            state_d.rdRemote = state_q.obj[rdIdx].remoteSeenFlag;
            // [R24] clearing read
            if (rdClear)
            begin
                state_d.obj[rdIdx].freshDataBit = 1'b0;
                state_d.obj[rdIdx].overwriteLostFlag = 1'b0;
                state_d.obj[rdIdx].remoteSeenFlag = 1'b0;
                state_d.obj[rdIdx].intPending = 1'b0;
            end
        end
        // transmit completion and launch
        if (state_q.txBusy)
        begin
            k = state_q.txIdx;
            if (txDone)
            begin
                state_d.txBusy = 1'b0;
                // [R7] transmit success
                state_d.txOk = 1'b1;
                state_d.stsIrq = 1'b1;
                state_d.obj[k].transmitPendingBit = 1'b0;
                // [R19] transmit interrupt enable
                if (state_q.obj[k].transmitIrqEnable)
                begin
                    state_d.obj[k].intPending = 1'b1;
                end
                // [R13] sender turns into a receiver
                if (state_q.obj[k].objType == REMOTE_REQUEST_SENDER)
                begin
                    state_d.obj[k].objType = OBJ_RX;
                end
            end
            else if (txFail)
            begin
                state_d.txBusy = 1'b0;
                // [R1] no automatic resend when retry is off
                if (!autoRetryEn)
                begin
                    state_d.obj[k].transmitPendingBit = 1'b0;
                end
            end
        end
        else if (|txReq)
        begin
            k = firstSet(txReq);
            state_d.txBusy = 1'b1;
            state_d.txIdx = k;
            state_d.txStart = 1'b1;
            state_d.txId = state_q.obj[k].objectIdentifier;
            state_d.txLong = state_q.obj[k].longIdentifierSelect;
            // [R13] request goes out without data
            state_d.txRemote = state_q.obj[k].objType == REMOTE_REQUEST_SENDER;
            state_d.txDlc = state_q.obj[k].dlc;
            state_d.txData = state_q.obj[k].data;
        end
        // reception
        if (rxFrame)
        begin
            // [R6] success regardless of filtering
            state_d.rxOk = 1'b1;
            state_d.stsIrq = 1'b1;
            if (|rxElig)
            begin
                k = firstSet(rxElig);
                // [R22] overwrite of unread data
                state_d.obj[k].overwriteLostFlag = state_q.obj[k].freshDataBit || state_d.obj[k].overwriteLostFlag;
                state_d.obj[k].freshDataBit = 1'b1;
                // [R19] receive interrupt enable
                if (state_q.obj[k].receiveIrqEnable)
                begin
                    state_d.obj[k].intPending = 1'b1;
                end
                if (rxRemote)
                begin
                    // [R14] request kept for software
                    state_d.obj[k].remoteSeenFlag = 1'b1;
                    // [R15] auto responder queues its data
                    if (state_q.obj[k].objType == AUTO_REMOTE_RESPONDER)
                    begin
                        state_d.obj[k].transmitPendingBit = 1'b1;
                    end
                end
                else
                begin
                    state_d.obj[k].dlc = rxDlc;
                    state_d.obj[k].data = rxData;
                end
            end
        end
        // [R8] [R9] [R10] last error code from engine
        if (errEvt)
        begin
            state_d.lec = errCode;
            state_d.stsIrq = 1'b1;
        end
        // [R3] bus-off
        state_d.busOff = busOffIn;
        // [R4] warning limit
        state_d.ewarn = (tecCount >= WARN_LIMIT) || (recCount >= WARN_LIMIT);
        // [R5] error passive
        state_d.epass = errPassiveIn;
        // [R11] object maps
        for (int i = 0; i < NUM_OBJ; i++)
        begin
            state_d.txMap[i] = state_d.obj[i].transmitPendingBit;
            state_d.newMap[i] = state_d.obj[i].freshDataBit;
            state_d.valMap[i] = state_d.obj[i].objectValidBit;
            intVec[i] = state_d.obj[i].intPending;
        end
        // [R23] status first, then lowest object number
        if (state_d.stsIrq)
        begin
            state_d.intId = INTID_STATUS;
        end
        else if (|intVec)
        begin
            state_d.intId = INTID_W'(firstSet(intVec)) + 16'h0001;
        end
        else
        begin
            state_d.intId = INTID_NONE;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q <= '0;
            state_q.lec <= LEC_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdValid = state_q.rdValid;
    assign rdId = state_q.rdId;
    assign rdLongId = state_q.rdLongId;
    assign rdDlc = state_q.rdDlc;
    assign rdData = state_q.rdData;
    assign rdFresh = state_q.rdFresh;
    assign rdLost = state_q.rdLost;
    assign rdRemote = state_q.rdRemote;
    assign busOffFlag = state_q.busOff;
    assign errorWarningFlag = state_q.ewarn;
    assign errorPassiveFlag = state_q.epass;
    assign receiveSuccessFlag = state_q.rxOk;
    assign transmitSuccessFlag = state_q.txOk;
    assign lastErrorCode = state_q.lec;
    assign statusIrqPend = state_q.stsIrq;
    assign pendingTransmitMap = state_q.txMap;
    assign unreadDataMap = state_q.newMap;
    assign configuredObjectMap = state_q.valMap;
    assign intId = state_q.intId;
    assign txStart = state_q.txStart;
    assign txId = state_q.txId;
    assign txLong = state_q.txLong;
    assign txRemote = state_q.txRemote;
    assign txDlc = state_q.txDlc;
    assign txData = state_q.txData;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_RETRY_OFF: assert property ( // [R1]
        state_q.txBusy && txFail && !txDone && !autoRetryEn && !cfgWr && !rxFrame
        |=> !pendingTransmitMap[$past(state_q.txIdx)])
        else $error("failed frame still pending with retry off");
    AST_STS_CLEAR: assert property ( // [R2]
        stsRd && !rxFrame && !errEvt && !(state_q.txBusy && txDone) |=> !statusIrqPend)
        else $error("status read did not clear status interrupt");
    AST_BUS_OFF: assert property ( // [R3]
        busOffIn |=> busOffFlag)
        else $error("bus-off flag missing");
    AST_WARN: assert property ( // [R4]
        1'b1 |=> errorWarningFlag == ($past(tecCount) >= 8'h60 || $past(recCount) >= 8'h60))
        else $error("warning flag wrong");
    AST_RXOK: assert property ( // [R6]
        rxFrame |=> receiveSuccessFlag && statusIrqPend)
        else $error("receive success not set");
    AST_TXOK: assert property ( // [R7]
        state_q.txBusy && txDone |=> transmitSuccessFlag)
        else $error("transmit success not set");
    AST_LEC: assert property ( // [R8]
        errEvt |=> lastErrorCode == $past(errCode))
        else $error("last error code not captured");
    AST_ONE_TX: assert property ( // [R13]
        txStart |=> !txStart [*2])
        else $error("second launch while busy");
    AST_READ_CLEAR: assert property ( // [R24]
        rdReq && rdClear && !rxFrame && !cfgWr |=> !unreadDataMap[$past(rdIdx)])
        else $error("clearing read left unread data");
    COV_RX: cover property (rxFrame && |rxElig);
    COV_TX: cover property (txStart ##[1:50] txDone);
    COV_RETRY: cover property (state_q.txBusy && txFail && autoRetryEn);

endmodule : cmo_status_core

/* File: design/cmo_pkg.sv */
// Purpose: shared constants and types of the CAN message object and status block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: error code values and the status interrupt id are local encodings
package cmo_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_OBJ = 32;
    localparam int IDX_W = 5;
    localparam int ID_W = 29;
    localparam int STD_ID_W = 11;
    localparam int DLC_W = 4;
    localparam int DATA_W = 64;
    localparam int INTID_W = 16;

    // ----------------------------------------
    // limits and codes
    // ----------------------------------------
    localparam logic [7:0] WARN_LIMIT = 8'h60;
    localparam logic [2:0] NO_ERROR_CODE = 3'h0;
    localparam logic [2:0] STUFFING_ERROR_CODE = 3'h1;
    localparam logic [2:0] FORMAT_ERROR_CODE = 3'h2;
    localparam logic [2:0] NO_ACKNOWLEDGE_CODE = 3'h3;
    localparam logic [2:0] RECESSIVE_BIT_ERROR_CODE = 3'h4;
    localparam logic [2:0] DOMINANT_BIT_ERROR_CODE = 3'h5;
    localparam logic [2:0] CHECKSUM_ERROR_CODE = 3'h6;
    localparam logic [2:0] LEC_RESET = NO_ERROR_CODE;
    localparam logic [INTID_W-1:0] INTID_NONE = 16'h0000;
    localparam logic [INTID_W-1:0] INTID_STATUS = 16'h8000;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        OBJ_TX,
        REMOTE_REQUEST_SENDER,
        OBJ_RX,
        REMOTE_REQUEST_RECEIVER,
        AUTO_REMOTE_RESPONDER
    } cmo_type_e;

    typedef struct packed {
        logic objectValidBit;
        logic transmitPendingBit;
        logic freshDataBit;
        logic overwriteLostFlag;
        logic remoteSeenFlag;
        logic intPending;
        logic transmitIrqEnable;
        logic receiveIrqEnable;
        logic identifierFilterEnable;
        logic directionFilterEnable;
        logic extendedOnlyFilter;
        logic longIdentifierSelect;
        logic chainContinueFlag;
        cmo_type_e objType;
        logic [ID_W-1:0] objectIdentifier;
        logic [ID_W-1:0] acceptanceMask;
        logic [DLC_W-1:0] dlc;
        logic [DATA_W-1:0] data;
    } cmo_obj_s;

endpackage : cmo_pkg

/* File: design/cmo_obj_match.sv */
// Purpose: acceptance test of one incoming frame against one message object
// Assumes: purely combinational, fed from registered object state
// Notes: one instance per object
`timescale 1ns/1ps
module cmo_obj_match
    import cmo_pkg::*;
(
    input wire logic objectValidBit,
    input wire cmo_type_e objType,
    input wire logic identifierFilterEnable,
    input wire logic directionFilterEnable,
    input wire logic extendedOnlyFilter,
    input wire logic longIdentifierSelect,
    input wire logic [ID_W-1:0] objectIdentifier,
    input wire logic [ID_W-1:0] acceptanceMask,
    input wire logic [ID_W-1:0] frameId,
    input wire logic frameLong,
    input wire logic frameRemote,
    output logic hit
);

    logic [ID_W-1:0] maskEff;
    logic idOk;
    logic rxClass;
    logic remoteClass;
    logic dirOk;
    logic formOk;

    always_comb
    begin
        // [R16] mask used only with id filtering
        maskEff = identifierFilterEnable ? acceptanceMask : {ID_W{1'b1}};
        if (longIdentifierSelect)
        begin
            idOk = (frameId & maskEff) == objectIdentifier;
        end
        else
        begin
            idOk = (frameId[STD_ID_W-1:0] & maskEff[STD_ID_W-1:0]) == objectIdentifier[STD_ID_W-1:0];
        end
        remoteClass = (objType == REMOTE_REQUEST_RECEIVER) || (objType == AUTO_REMOTE_RESPONDER);
        rxClass = remoteClass || (objType == OBJ_RX);
        // [R17] direction agrees with type
        dirOk = !directionFilterEnable || (frameRemote == remoteClass);
        // [R18] extended frames only
        formOk = !extendedOnlyFilter || frameLong;
        hit = objectValidBit && rxClass && dirOk && formOk && idOk;
    end

endmodule : cmo_obj_match

/* File: tb/cmo_far_node.sv */
// Purpose: far node model answering each launched frame after a few cycles
// Assumes: launch pulse one cycle wide, same clock as the core
// Notes: failOnce arms a single failed answer
`timescale 1ns/1ps
module cmo_far_node
    import cmo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic txStart,
    input wire logic failOnce,
    output logic txDone,
    output logic txFail
);
    logic [2:0] cnt;
    logic busy;
    logic arm;
    always @(posedge ref_clk)
    begin
        txDone <= 1'b0;
        txFail <= 1'b0;
        if (failOnce)
            arm <= 1'b1;
        if (sys_rst)
        begin
            busy <= 1'b0;
            arm <= 1'b0;
        end
        else if (txStart)
        begin
            busy <= 1'b1;
            cnt <= 3'h3;
        end
        else if (busy)
        begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1)
            begin
                busy <= 1'b0;
                txFail <= arm;
                txDone <= !arm;
                arm <= 1'b0;
            end
        end
    end
endmodule : cmo_far_node

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the status and message object core
// Assumes: inputs change 1 ns after the rising edge
// Notes: status cases run from a table, object cases by hand
`timescale 1ns/1ps
module tb_top;
    import cmo_pkg::*;
    logic ref_clk = 0, sys_rst = 1, autoRetryEn = 0, cfgWr = 0, cfgValid = 1, cfgLongId = 0;
    logic cfgIdFilter = 0, cfgDirFilter = 0, cfgExtFilter = 0, cfgChain = 0, cfgTxIrqEn = 1, cfgRxIrqEn = 0;
    logic rdReq = 0, rdClear = 0, stsRd = 0, rxFrame = 0, rxLong = 0, rxRemote = 0, errEvt = 0;
    logic busOffIn = 0, errPassiveIn = 0, failOnce = 0, txDone, txFail, txStart, txLong, txRemote;
    logic [4:0] cfgIdx = 0, rdIdx = 0;
    cmo_type_e cfgType = OBJ_RX;
    logic [28:0] cfgId = 0, cfgMask = 0, rxId = 0, rdId, txId, lastId;
    logic [3:0] cfgDlc = 4'h8, rxDlc = 4'h8, rdDlc, txDlc;
    logic [63:0] cfgData = 0, rxData = 0, rdData, txData;
    logic [2:0] errCode = 0, lastErrorCode;
    logic [7:0] tecCount = 0, recCount = 0;
    logic rdValid, rdLongId, rdFresh, rdLost, rdRemote, busOffFlag, errorWarningFlag, errorPassiveFlag;
    logic receiveSuccessFlag, transmitSuccessFlag, statusIrqPend, lastRemote;
    logic [31:0] pendingTransmitMap, unreadDataMap, configuredObjectMap;
    logic [15:0] intId;
    int fails = 0, checks = 0, nStart = 0, nRead = 0;
    logic [23:0] rows [6] = '{24'h5f0008, 24'h600012, 24'h00601a, 24'h005f61, 24'h0000ac, 24'hff0032};
    cmo_status_core u_cmo_status_core (.*);
    cmo_far_node u_cmo_far_node (.*);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (txStart === 1'b1)
        begin
            nStart <= nStart + 1;
            lastId <= txId;
            lastRemote <= txRemote;
        end
    always @(posedge ref_clk)
        if (rdValid === 1'b1)
            nRead <= nRead + 1;
    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task conclude;
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task cfg(input logic [4:0] i, input cmo_type_e t, input logic [28:0] id, m, input logic [3:0] f);
        {cfgIdx, cfgId, cfgMask} = {i, id, m};
        cfgType = t;
        {cfgChain, cfgIdFilter, cfgDirFilter, cfgRxIrqEn} = f;
        cfgData = {35'h0, id};
        cfgWr = 1;
        tick;
        cfgWr = 0;
        tick;
    endtask : cfg
    task rx(input logic [28:0] id, input logic l, r, input logic [63:0] d);
        {rxId, rxLong, rxRemote, rxData} = {id, l, r, d};
        rxFrame = 1;
        tick;
        rxFrame = 0;
        tick;
    endtask : rx
    task rd(input logic [4:0] i);
        {rdIdx, rdClear, rdReq} = {i, 2'b11};
        tick;
        rdReq = 0;
        tick;
    endtask : rd
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        conclude;
    end
    initial
    begin
        repeat (12) tick;
        chk({busOffFlag, errorWarningFlag, errorPassiveFlag, receiveSuccessFlag, transmitSuccessFlag}, 0);
        chk({intId, lastErrorCode, pendingTransmitMap}, 0);
        chk(configuredObjectMap, 0);
        sys_rst = 0;
        tick;
        // status flags from table
        foreach (rows[i])
        begin
            {tecCount, recCount, busOffIn, errPassiveIn, errCode} = rows[i][23:3];
            errEvt = 1;
            tick;
            errEvt = 0;
            tick;
            chk({busOffFlag, errorWarningFlag, errorPassiveFlag}, rows[i][2:0]);
            chk(lastErrorCode, rows[i][5:3]);
        end
        {tecCount, busOffIn} = 0;
        cfg(0, OBJ_RX, 29'h400, 29'h7f8, 4'hd);
        cfg(1, OBJ_RX, 29'h400, 29'h7f8, 4'h5);
        chk(configuredObjectMap, 32'h3);
        rx(29'h403, 0, 0, 64'ha1);
        rx(29'h408, 0, 0, 64'hb2);
        chk(unreadDataMap, 32'h1);
        chk(receiveSuccessFlag, 1);
        chk(intId, 16'h8000);
        stsRd = 1;
        tick;
        stsRd = 0;
        tick;
        chk({statusIrqPend, intId}, 17'h1);
        rx(29'h405, 0, 0, 64'hc3);
        chk(unreadDataMap, 32'h3);
        rx(29'h406, 0, 0, 64'hd4);
        rd(0);
        chk(rdData, 64'ha1);
        chk(unreadDataMap, 32'h2);
        rd(1);
        chk({rdLost, rdData}, {1'b1, 64'hd4});
        chk({nRead[7:0], rdFresh, rdLongId, rdDlc, rdId}, {8'd2, 1'b1, 1'b0, 4'h8, 29'h400});
        cfgExtFilter = 1;
        cfg(8, OBJ_RX, 29'h12, 0, 4'h0);
        cfgExtFilter = 0;
        rx(29'h12, 0, 0, 0);
        chk(unreadDataMap[8], 0);
        rx(29'h12, 1, 0, 0);
        chk(unreadDataMap[8], 1);
        cfg(9, OBJ_RX, 29'h33, 0, 4'h2);
        rx(29'h33, 0, 1, 0);
        chk(unreadDataMap[9], 0);
        rx(29'h33, 0, 0, 0);
        chk(unreadDataMap[9], 1);
        autoRetryEn = 1;
        failOnce = 1;
        cfg(5, OBJ_TX, 29'h123, 0, 4'h0);
        failOnce = 0;
        repeat (20) tick;
        chk({nStart[7:0], transmitSuccessFlag, pendingTransmitMap}, {8'd2, 1'b1, 32'h0});
        autoRetryEn = 0;
        failOnce = 1;
        cfg(5, OBJ_TX, 29'h124, 0, 4'h0);
        failOnce = 0;
        repeat (20) tick;
        chk({nStart, pendingTransmitMap}, {32'd3, 32'h0});
        cfg(6, REMOTE_REQUEST_SENDER, 29'h77, 0, 4'h0);
        repeat (20) tick;
        chk({lastId, lastRemote}, {29'h77, 1'b1});
        rx(29'h77, 0, 0, 64'h5);
        chk(unreadDataMap[6], 1);
        cfg(7, AUTO_REMOTE_RESPONDER, 29'h88, 0, 4'h0);
        rx(29'h88, 0, 1, 0);
        repeat (20) tick;
        chk({nStart, lastId, lastRemote}, {32'd5, 29'h88, 1'b0});
        chk({txLong, txDlc, txData[31:0]}, {1'b0, 4'h8, 32'h88});
        cfg(10, REMOTE_REQUEST_RECEIVER, 29'h99, 0, 4'h1);
        rx(29'h99, 0, 1, 0);
        rd(10);
        repeat (10) tick;
        chk({nStart[7:0], rdRemote, rdFresh}, {8'd5, 2'b11});
        conclude;
    end
endmodule : tb_top
